/* spimh_consts.vh */
/*
 * Constants for the SPI host-side controller: register offsets, field
 * positions, reset values, states and timing.
 * Assumes inclusion by bare name from design files in the same folder.
 */
`ifndef SPIMH_CONSTS_VH
`define SPIMH_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave
// ----------------------------------------------------------------------
`define SPIMH_OFS_CTRL 8'h00
`define SPIMH_OFS_STAT 8'h04
`define SPIMH_OFS_TX 8'h08
`define SPIMH_OFS_RX 8'h0C
`define SPIMH_OFS_DIV 8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SPIMH_CTRL_CPOL 0
`define SPIMH_CTRL_CPHA 1
`define SPIMH_CTRL_SEL 2
`define SPIMH_CTRL_AUTO 3
`define SPIMH_CTRL_W 4
`define SPIMH_CTRL_RST 4'h8

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SPIMH_ST_BUSY 0
`define SPIMH_ST_DONE 1
`define SPIMH_ST_COLL 2

// ----------------------------------------------------------------------
// Clock divider and byte size
// ----------------------------------------------------------------------
`define SPIMH_DIV_W 8
`define SPIMH_DIV_RST 8'h10
`define SPIMH_DIV_MIN 8'h02
`define SPIMH_BITS 4'h8
`define SPIMH_HALF_NS 100
`define SPIMH_CLK_NS 5

// ----------------------------------------------------------------------
// Main state machine encodings
// ----------------------------------------------------------------------
`define SPIMH_S_IDLE 2'h0
`define SPIMH_S_SETUP 2'h1
`define SPIMH_S_SHIFT 2'h2
`define SPIMH_S_HOLD 2'h3

`endif

/* spimh_buf.v */
/*
 * Two-entry byte store; only entry 0 is written, holding the last transmitted byte.
 * Assumes one writer per port on clk; read data come from a register.
 */
module spimh_buf (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Write side
    input wire wr_en,
    input wire wr_addr,
    input wire [7:0] wr_data,
    // Read side
    input wire rd_addr,
    output reg [7:0] rd_data
);

reg [7:0] mem_reg [0:1];

always @(posedge clk)
begin
    if (!rst_b)
    begin
        mem_reg[0] <= 8'h00;
        mem_reg[1] <= 8'h00;
        rd_data <= 8'h00;
    end
    else
    begin
        if (wr_en)
        begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
end

endmodule

/* spimh_ctrl.v */
/*
 * SPI master controller that drives an external byte-wide SPI peripheral
 * working as a slave, over its SCK, MOSI, MISO and SS pins.
 * Assumes an AHB-Lite master on clk with single word transfers and a
 * peripheral that samples and shifts on the edges chosen by CPOL/CPHA.
 */
`include "spimh_consts.vh"

module spimh_ctrl (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // SPI pins
    output reg sck,
    output reg mosi,
    output reg mosi_oe,
    input wire miso,
    output reg ss_b
);

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
localparam integer GAP_INT =
    (`SPIMH_HALF_NS + `SPIMH_CLK_NS - 1) / `SPIMH_CLK_NS;
localparam [`SPIMH_DIV_W-1:0] GAP_CYC = GAP_INT[`SPIMH_DIV_W-1:0];

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [`SPIMH_CTRL_W-1:0] ctrl_reg;
reg [`SPIMH_DIV_W-1:0] div_reg;
reg [1:0] state_reg;
reg [`SPIMH_DIV_W-1:0] cnt_reg;
reg [3:0] bit_reg;
reg phase_reg;
reg [7:0] sh_reg;
reg done_reg;
reg coll_reg;
reg miso_s1_reg;
reg miso_s2_reg;
reg wr_pend_reg;
reg [7:0] addr_reg;
reg rd_pend_reg;
reg [7:0] rx_byte_reg;
wire [7:0] buf_rd;

wire busy = (state_reg != `SPIMH_S_IDLE);
wire addr_ok = hsel && hready && htrans[1];

function [`SPIMH_DIV_W-1:0] spimh_half;
    input [`SPIMH_DIV_W-1:0] d;
    begin
        if (d < `SPIMH_DIV_MIN)
            spimh_half = `SPIMH_DIV_MIN;
        else
            spimh_half = d;
    end
endfunction

// ----------------------------------------------------------------------
// Input synchroniser
// ----------------------------------------------------------------------
always @(posedge clk)
begin
    if (!rst_b)
    begin
        miso_s1_reg <= 1'b0;
        miso_s2_reg <= 1'b0;
    end
    else
    begin
        miso_s1_reg <= miso;
        miso_s2_reg <= miso_s1_reg;
    end
end

// ----------------------------------------------------------------------
// Bus slave: writes land in the data phase; reads answer after one wait.
// ----------------------------------------------------------------------
wire wr_data = wr_pend_reg;
wire tx_wr = wr_data && (addr_reg == `SPIMH_OFS_TX);

always @(posedge clk)
begin
    if (!rst_b)
    begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        addr_reg <= 8'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= 32'h0000_0000;
        ctrl_reg <= `SPIMH_CTRL_RST;
        div_reg <= `SPIMH_DIV_RST;
    end
    else
    begin
        wr_pend_reg <= addr_ok && hwrite;
        rd_pend_reg <= addr_ok && !hwrite;
        hreadyout <= !(addr_ok && !hwrite);
        if (addr_ok)
        begin
            addr_reg <= haddr;
        end
        if (wr_data && addr_reg == `SPIMH_OFS_CTRL && !busy)
        begin
            ctrl_reg <= hwdata[`SPIMH_CTRL_W-1:0];
        end
        if (wr_data && addr_reg == `SPIMH_OFS_DIV && !busy)
        begin
            div_reg <= hwdata[`SPIMH_DIV_W-1:0];
        end
        if (rd_pend_reg)
        begin
            case (addr_reg)
                `SPIMH_OFS_CTRL: hrdata <= {28'h0000000, ctrl_reg};
                `SPIMH_OFS_STAT: hrdata <= {29'h0000000, coll_reg, done_reg, busy};
                `SPIMH_OFS_TX: hrdata <= {24'h000000, buf_rd};
                `SPIMH_OFS_RX: hrdata <= {24'h000000, rx_byte_reg};
                `SPIMH_OFS_DIV: hrdata <= {24'h000000, div_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// Status flags: a new event wins over a clear in the same cycle.
// ----------------------------------------------------------------------
wire stat_rd = rd_pend_reg && (addr_reg == `SPIMH_OFS_STAT);
wire rx_rd = rd_pend_reg && (addr_reg == `SPIMH_OFS_RX);
wire byte_end;

always @(posedge clk)
begin
    if (!rst_b)
    begin
        done_reg <= 1'b0;
        coll_reg <= 1'b0;
    end
    else
    begin
        if (byte_end)
            done_reg <= 1'b1;
        else if (rx_rd)
            done_reg <= 1'b0;
        if (tx_wr && busy)
            coll_reg <= 1'b1;
        else if (stat_rd)
            coll_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Shift engine. Edge 0 of each bit pair is the capture edge, the leading SCK edge only with CPHA clear.
// ----------------------------------------------------------------------
wire cnt_end = (cnt_reg == 8'h00);
assign byte_end = (state_reg == `SPIMH_S_SHIFT) && cnt_end && phase_reg
    && (bit_reg == 4'h1);

always @(posedge clk)
begin
    if (!rst_b)
    begin
        state_reg <= `SPIMH_S_IDLE;
        cnt_reg <= 8'h00;
        bit_reg <= 4'h0;
        phase_reg <= 1'b0;
        sh_reg <= 8'h00;
        rx_byte_reg <= 8'h00;
        sck <= 1'b0;
        mosi <= 1'b0;
        mosi_oe <= 1'b0;
        ss_b <= 1'b1;
    end
    else
    begin
        case (state_reg)
            `SPIMH_S_IDLE:
            begin
                sck <= ctrl_reg[`SPIMH_CTRL_CPOL];
                // A held select under CPHA one survives idle until CTRL is rewritten with CPHA or AUTO clear.
                ss_b <= !ctrl_reg[`SPIMH_CTRL_SEL]
                    && !(ctrl_reg[`SPIMH_CTRL_CPHA] && ctrl_reg[`SPIMH_CTRL_AUTO] && !ss_b);
                mosi_oe <= 1'b0;
                if (tx_wr)
                begin
                    sh_reg <= hwdata[7:0];
                    ss_b <= 1'b0;
                    mosi_oe <= 1'b1;
                    mosi <= hwdata[7];
                    cnt_reg <= spimh_half(div_reg);
                    bit_reg <= `SPIMH_BITS;
                    phase_reg <= 1'b0;
                    state_reg <= `SPIMH_S_SETUP;
                end
            end
            `SPIMH_S_SETUP:
            begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_end)
                begin
                    cnt_reg <= spimh_half(div_reg);
                    state_reg <= `SPIMH_S_SHIFT;
                    if (ctrl_reg[`SPIMH_CTRL_CPHA])
                        sck <= !sck;
                end
            end
            `SPIMH_S_SHIFT:
            begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_end)
                begin
                    cnt_reg <= spimh_half(div_reg);
                    phase_reg <= !phase_reg;
                    if (!phase_reg)
                    begin
                        // Capture edge: with CPHA set it is the second one.
                        sh_reg <= {sh_reg[6:0], miso_s2_reg};
                        sck <= !sck;
                    end
                    else
                    begin
                        mosi <= sh_reg[7];
                        bit_reg <= bit_reg - 4'h1;
                        if (!ctrl_reg[`SPIMH_CTRL_CPHA] || bit_reg != 4'h1)
                            sck <= !sck;
                        if (bit_reg == 4'h1)
                        begin
                            rx_byte_reg <= sh_reg;
                            mosi_oe <= 1'b0;
                            sck <= ctrl_reg[`SPIMH_CTRL_CPOL];
                            cnt_reg <= GAP_CYC;
                            state_reg <= `SPIMH_S_HOLD;
                        end
                    end
                end
            end
            `SPIMH_S_HOLD:
            begin
                cnt_reg <= cnt_reg - 8'h01;
                if (!ctrl_reg[`SPIMH_CTRL_CPHA] || !ctrl_reg[`SPIMH_CTRL_AUTO])
                    ss_b <= 1'b1;
                else
                    ss_b <= 1'b0;
                if (cnt_end)
                begin
                    mosi_oe <= 1'b0;
                    state_reg <= `SPIMH_S_IDLE;
                end
            end
            default: state_reg <= `SPIMH_S_IDLE;
        endcase
    end
end

// Last transmitted byte kept for read-back.
spimh_buf u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(tx_wr && !busy),
    .wr_addr(1'b0),
    .wr_data(hwdata[7:0]),
    .rd_addr(1'b0),
    .rd_data(buf_rd)
);

endmodule

/* spimh_ctrl_monitor.sv */
/*
 * Monitor for spimh_ctrl: bus answer timing and SPI framing at its ports.
 * Assumes one clock domain and a bind to every spimh_ctrl instance.
 */
module spimh_ctrl_monitor (
    // Clock, reset and bus
    input logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp,
    input logic [7:0] haddr,
    input logic [1:0] htrans,
    input logic [2:0] hsize,
    input logic [31:0] hwdata, hrdata,
    // SPI pins
    input logic sck, mosi, mosi_oe, miso, ss_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sp, mp;
    logic [4:0] ec, q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----
    // Edge count per frame and quiet time since the last frame edge.
    // ----
    always_ff @(posedge clk)
    begin
        sp <= sck;
        mp <= mosi_oe;
        if (!rst_b)
        begin
            ec <= 5'h00;
            q <= 5'h14;
        end
        else
        begin
            ec <= (mosi_oe && !mp) ? 5'h00 : ec + {4'h0, sck != sp};
            q <= (mosi_oe && sck != sp) ? 5'h00 : q + {4'h0, q < 5'h14};
        end
    end
    resp_okay_a: assert property (hresp == 1'h0)
        else $error("bus response not okay");
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    write_ready_a: assert property (hsel && hready && htrans[1] && hwrite
        |=> hreadyout) else $error("write data phase stretched");
    frame_select_a: assert property (mosi_oe |-> !ss_b)
        else $error("frame driven without select");
    half_period_a: assert property (mosi_oe && $changed(sck) |=> $stable(sck) [*2])
        else $error("clock half period too short");
    edge_count_a: assert property ($fell(mosi_oe) |=> ec == 5'h10)
        else $error("frame edge count wrong");
    byte_gap_a: assert property ($rose(mosi_oe) |-> q >= 5'h14)
        else $error("gap between bytes too short");
    rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
endmodule

bind spimh_ctrl spimh_ctrl_monitor spimh_ctrl_monitor_inst (.*);

/* spimh_slave_model.sv */
/*
 * Behavioural model of the byte-wide SPI peripheral working as a slave.
 * Assumes the controller drives sck, mosi and ss_b in a matching mode.
 */
module spimh_slave_model (
    // SPI pins
    input logic sck,
    input logic mosi,
    input logic ss_b,
    output logic miso,
    // Mode and data
    input logic cpol,
    input logic cpha,
    input logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    logic done = 1'h0;
    logic overrun_flag = 1'h0;
    int n = 0;
    // Master-mode duties never arise here: this model only follows.
    initial miso = 1'h0;
    always @(negedge ss_b)
    begin
        sh = tx_byte;
        done = 1'h0;
        n = 0;
        miso = sh[7];
    end
    // A released line shows the inverse of its last bit, never a stale copy.
    always @(posedge ss_b)
        miso = ~miso;
    always @(sck)
    begin
        if (!ss_b && ((sck != cpol) ^ cpha))
        begin
            sh = {sh[6:0], mosi};
            n++;
            if (n == 8)
            begin
                rx_byte = sh;
                if (done)
                    overrun_flag = 1'h1;
                done = 1'h1;
                n = 0;
            end
        end
        else if (!ss_b)
        begin
            if (n == 0 && cpha)
                sh = tx_byte;
            miso = sh[7];
        end
    end
endmodule

/* spimh_ctrl_tb.sv */
/*
 * Testbench for spimh_ctrl: bus tasks, random bytes in all four modes.
 * Assumes the slave model and the bound monitor are compiled first.
 */
`include "spimh_consts.vh"
module spimh_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, cpol = 1'h0, cpha = 1'h0;
    logic miso, hreadyout, hresp, sck, mosi, mosi_oe, ss_b;
    logic [7:0] haddr = 8'h00, stx = 8'h00, srx;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, r, x = 32'h36;
    int failures = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    spimh_ctrl spimh_ctrl_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sck(sck), .mosi(mosi), .mosi_oe(mosi_oe), .miso(miso), .ss_b(ss_b));
    spimh_slave_model spimh_slave_model_inst (.sck(sck), .mosi(mosi), .ss_b(ss_b),
        .miso(miso), .cpol(cpol), .cpha(cpha), .tx_byte(stx), .rx_byte(srx));
    // ----
    // Shared tasks.
    // ----
    function automatic logic [7:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x[7:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task automatic xfer(input logic [7:0] d, input logic c);
        logic [7:0] e;
        e = rnd();
        stx = e;
        bus(1'h1, `SPIMH_OFS_TX, {24'h0, d});
        if (c)
        begin
            bus(1'h1, `SPIMH_OFS_TX, {24'h0, ~d});
            bus(1'h0, `SPIMH_OFS_STAT, 32'h0);
            chk({29'h0, r[2:0]}, 32'h5);
            bus(1'h0, `SPIMH_OFS_STAT, 32'h0);
            chk({29'h0, r[2:0]}, 32'h1);
        end
        do bus(1'h0, `SPIMH_OFS_STAT, 32'h0);
        while (r[`SPIMH_ST_DONE] !== 1'h1 || r[`SPIMH_ST_BUSY] !== 1'h0);
        chk({24'h0, srx}, {24'h0, d});
        bus(1'h0, `SPIMH_OFS_RX, 32'h0);
        chk(r, {24'h0, e});
        bus(1'h0, `SPIMH_OFS_STAT, 32'h0);
        chk({31'h0, r[`SPIMH_ST_DONE]}, 32'h0);
    endtask
    task automatic wrap_up();
        $display("counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----
    // Main sequence and watchdog.
    // ----
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        bus(1'h0, `SPIMH_OFS_CTRL, 32'h0);
        chk(r, {28'h0, `SPIMH_CTRL_RST});
        bus(1'h0, `SPIMH_OFS_DIV, 32'h0);
        chk(r, {24'h0, `SPIMH_DIV_RST});
        bus(1'h0, 8'h20, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        bus(1'h1, `SPIMH_OFS_DIV, {24'h0, `SPIMH_DIV_MIN});
        $display("test registers done");
        for (int m = 0; m < 4; m++)
        begin
            cpol = m[0];
            cpha = m[1];
            bus(1'h1, `SPIMH_OFS_CTRL, {30'h0, m[1:0]});
            xfer(rnd(), 1'h0);
            xfer(8'h80, m[0]);
            chk({31'h0, sck}, {31'h0, m[0]});
            chk({31'h0, ss_b}, 32'h1);
            $display("test mode %0d done", m);
        end
        cpol = 1'h0;
        cpha = 1'h1;
        bus(1'h1, `SPIMH_OFS_CTRL, 32'hA);
        xfer(rnd(), 1'h0);
        chk({31'h0, ss_b}, 32'h0);
        xfer(8'h01, 1'h0);
        $display("test held select done");
        cpha = 1'h0;
        bus(1'h1, `SPIMH_OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, ss_b}, 32'h1);
        bus(1'h1, `SPIMH_OFS_CTRL, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, ss_b}, 32'h0);
        bus(1'h1, `SPIMH_OFS_CTRL, 32'h0);
        bus(1'h1, `SPIMH_OFS_DIV, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, ss_b}, 32'h1);
        xfer(rnd(), 1'h0);
        $display("test select and clamp done");
        wrap_up();
    end
endmodule
